// File: inc/oejs_pkg.sv
// Constants for the analogue output enable and jack switch control block.
// Assumes a 16-bit register port with 7-bit addresses and one 25 MHz clock.
package oejs_pkg;

   // Register port geometry
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;

   // Register addresses
   localparam logic [6:0] ADR_POWER_MANAGEMENT_ONE = 7'h01;
   localparam logic [6:0] ADR_POWER_MANAGEMENT_THREE = 7'h03;
   localparam logic [6:0] ADR_ADDITIONAL_CONTROL = 7'h07;
   localparam logic [6:0] ADR_SWITCH_PIN_CONTROL = 7'h08;
   localparam logic [6:0] ADR_OUTPUT_CONTROL = 7'h31;
   localparam logic [6:0] ADR_MONO_MIXER_CONTROL = 7'h38;
   localparam logic [6:0] ADR_EVENT_STATUS = 7'h3a;
   localparam logic [6:0] ADR_EVENT_MASK = 7'h3b;

   // Power management one fields
   localparam int BIT_AMP_BIAS_ON = 3;
   localparam int BIT_MIDRAIL_BUFFER_ON = 2;

   // Power management three fields
   localparam int BIT_SINGLE_OUT_ON = 7;
   localparam int BIT_SPK_NEG_ON = 6;
   localparam int BIT_SPK_POS_ON = 5;
   localparam int BIT_SINGLE_MIXER_ON = 3;
   localparam int BIT_SPK_MIXER_ON = 2;

   // Additional control fields
   localparam int BIT_SLOW_TICK_ON = 0;

   // Switch pin control fields
   localparam int PFS_LSB = 0;
   localparam int PFS_W = 3;
   localparam int BIT_SWITCH_PIN_INVERT = 3;
   localparam logic [2:0] PFS_OUTPUT_SWITCH = 3'h1;
   localparam logic [2:0] PFS_RESET = 3'h0;

   // Output control fields
   localparam int BIT_TIEOFF_RES_SEL = 0;
   localparam int BIT_OVERTEMP_SHUTDOWN_ON = 1;
   localparam logic OVERTEMP_SHUTDOWN_RESET = 1'b1;

   // Mono mixer control fields
   localparam int BIT_BYPASS_ATTEN_SINGLE = 7;
   localparam int BIT_SINGLE_OUT_SILENCE = 6;
   localparam int BIT_AUX_TO_SINGLE_SEL = 2;
   localparam int BIT_BYPASS_TO_SINGLE_SEL = 1;
   localparam int BIT_DAC_TO_SINGLE_SEL = 0;

   // Event status and mask fields
   localparam int EVT_W = 2;
   localparam int EVT_OVERTEMP = 0;
   localparam int EVT_SWITCH_CHANGE = 1;

   // Slow tick period is two to this power master clock periods
   localparam int SLOW_DIV_LOG2 = 21;

   // Register reset value
   localparam logic [15:0] REG_ZERO = 16'h0000;

endpackage

// File: verilog/oejs_debounce.sv
// Debouncer for the output switch pin.
// Assumes the pin is asynchronous and that tick_i is a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
module oejs_debounce (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic pin_i,
   input wire logic tick_i,
   output logic level_o
);
   logic meta_ff;
   logic sync_ff;
   logic sample_ff;
   logic level_ff;

   // Two flip-flops before anything looks at the pin
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= pin_i;
         sync_ff <= meta_ff;
      end
   end

   // New level only after two equal samples on consecutive ticks
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sample_ff <= 1'b0;
         level_ff <= 1'b0;
      end else if (tick_i) begin
         sample_ff <= sync_ff;
         if (sync_ff == sample_ff) begin
            level_ff <= sample_ff; // [R13] [R18]
         end
      end
   end

   assign level_o = level_ff;
endmodule
`default_nettype wire

// File: verilog/oejs_top.sv
// Output stage enables, mono mixer settings and jack driven output switch.
// Assumes a single 25 MHz clock, a synchronous reset and a strobed register port.
// Function
// [R1] DAC, bypass and aux feed the mono mixer when bits 0,1,2 set; reset 0.
// [R2] Bit 7 of mono mixer control attenuates bypass by 10 dB; reset 0.
// [R3] Bit 6 mutes mono output to mid-rail level only; reset 0.
// [R4] Power management three holds output and mixer enables; all reset off.
// [R5] Power management one holds amp bias bit 3, mid-rail buffer bit 2.
// [R6] Software should not enable outputs while the mid-rail buffer is off.
// [R7] Output control bit 0 picks 1k or 30k tie-off; reset 1k.
// [R8] Disabled outputs get the tie-off; enabled outputs drive actively.
// [R9] Two-wire mode with pin function 001 makes the pin a switch input.
// [R10] Invert bit set flips the sensed switch pin level.
// [R11] Level 0 gates speakers on, level 1 gates mono on, each if enabled.
// [R12] Software enables speakers and mono before relying on the switch.
// [R13] The switch pin is debounced in switch mode.
// [R14] Debounce runs on a slow power-of-two tick, only while enabled.
// [R15] Output control bit 1 enables thermal shutdown; reset 1.
// [R16] Over-temperature assertion raises an interrupt event.
// [R17] Additional control bit 0 enables the slow tick; reset 0.
// [R18] A new pin level needs equal samples on two consecutive ticks.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module oejs_top #(
   parameter int SLOW_DIV_LOG2 = oejs_pkg::SLOW_DIV_LOG2
) (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   // Register port
   input wire logic [oejs_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [oejs_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [oejs_pkg::DATA_W-1:0] RDATA_O,
   // Pins and analogue status
   input wire logic SELECT_OR_SWITCH_PIN_I,
   input wire logic TWO_WIRE_MODE_I,
   input wire logic OVERTEMP_I,
   // Mono mixer controls
   output logic DAC_TO_SINGLE_SEL_O,
   output logic BYPASS_TO_SINGLE_SEL_O,
   output logic AUX_TO_SINGLE_SEL_O,
   output logic BYPASS_ATTEN_SINGLE_O,
   output logic SINGLE_OUT_SILENCE_O,
   // Power controls
   output logic AMP_BIAS_ON_O,
   output logic MIDRAIL_BUFFER_ON_O,
   output logic SINGLE_MIXER_ON_O,
   output logic SPK_MIXER_ON_O,
   // Output stage drive, low means resistive tie-off; then the tie-off resistor select
   output logic SINGLE_LINE_OUT_DRIVE_O,
   output logic SPEAKER_POS_DRIVE_O,
   output logic SPEAKER_NEG_DRIVE_O,
   output logic TIEOFF_RES_SEL_O,
   // Thermal, slow tick enable and interrupt
   output logic OVERTEMP_SHUTDOWN_ON_O,
   output logic SLOW_TICK_ON_O,
   output logic IRQ_O
);
   // Software state
   logic amp_bias_on_ff;
   logic midrail_buffer_on_ff;
   logic single_out_on_ff;
   logic spk_neg_on_ff;
   logic spk_pos_on_ff;
   logic single_mixer_on_ff;
   logic spk_mixer_on_ff;
   logic slow_tick_on_ff;
   logic [oejs_pkg::PFS_W-1:0] pin_function_sel_ff;
   logic switch_pin_invert_ff;
   logic tieoff_res_sel_ff;
   logic overtemp_shutdown_on_ff;
   logic bypass_atten_single_ff;
   logic single_out_silence_ff;
   logic aux_to_single_sel_ff;
   logic bypass_to_single_sel_ff;
   logic dac_to_single_sel_ff;
   logic [oejs_pkg::EVT_W-1:0] evt_status_ff;
   logic [oejs_pkg::EVT_W-1:0] evt_mask_ff;
   logic [oejs_pkg::DATA_W-1:0] rdata_ff;
   logic [oejs_pkg::DATA_W-1:0] nxt_rdata;

   // Derived state
   logic [SLOW_DIV_LOG2-1:0] div_ff;
   logic tick_ff;
   logic mode_meta_ff;
   logic mode_sync_ff;
   logic ot_meta_ff;
   logic ot_sync_ff;
   logic ot_prev_ff;
   logic pin_level;
   logic eff_level_ff;
   logic eff_valid_ff;
   logic switch_mode;
   logic eff_level;
   logic nxt_spk_pos;
   logic nxt_spk_neg;
   logic nxt_single;
   logic ot_shutdown;
   logic [oejs_pkg::EVT_W-1:0] evt_set;
   logic status_rd;
   logic wr_pm1;
   logic wr_pm3;
   logic wr_add;
   logic wr_pin;
   logic wr_out;
   logic wr_mix;
   logic wr_mask;
   logic out_pos_ff;
   logic out_neg_ff;
   logic out_single_ff;
   logic irq_ff;

   // Address decode for writes and the status read
   assign wr_pm1 = WR_I && (ADDR_I == oejs_pkg::ADR_POWER_MANAGEMENT_ONE);
   assign wr_pm3 = WR_I && (ADDR_I == oejs_pkg::ADR_POWER_MANAGEMENT_THREE);
   assign wr_add = WR_I && (ADDR_I == oejs_pkg::ADR_ADDITIONAL_CONTROL);
   assign wr_pin = WR_I && (ADDR_I == oejs_pkg::ADR_SWITCH_PIN_CONTROL);
   assign wr_out = WR_I && (ADDR_I == oejs_pkg::ADR_OUTPUT_CONTROL);
   assign wr_mix = WR_I && (ADDR_I == oejs_pkg::ADR_MONO_MIXER_CONTROL);
   assign wr_mask = WR_I && (ADDR_I == oejs_pkg::ADR_EVENT_MASK);
   assign status_rd = RD_I && (ADDR_I == oejs_pkg::ADR_EVENT_STATUS);

   // Power management one
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         amp_bias_on_ff <= 1'b0;
         midrail_buffer_on_ff <= 1'b0;
      end else if (wr_pm1) begin
         amp_bias_on_ff <= WDATA_I[oejs_pkg::BIT_AMP_BIAS_ON]; // [R5]
         midrail_buffer_on_ff <= WDATA_I[oejs_pkg::BIT_MIDRAIL_BUFFER_ON]; // [R5]
      end
   end

   // Power management three; enabling with the buffer off is allowed, only unwise
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         single_out_on_ff <= 1'b0;
         spk_neg_on_ff <= 1'b0;
         spk_pos_on_ff <= 1'b0;
         single_mixer_on_ff <= 1'b0;
         spk_mixer_on_ff <= 1'b0;
      end else if (wr_pm3) begin
         single_out_on_ff <= WDATA_I[oejs_pkg::BIT_SINGLE_OUT_ON]; // [R4] [R6]
         spk_neg_on_ff <= WDATA_I[oejs_pkg::BIT_SPK_NEG_ON]; // [R4]
         spk_pos_on_ff <= WDATA_I[oejs_pkg::BIT_SPK_POS_ON]; // [R4]
         single_mixer_on_ff <= WDATA_I[oejs_pkg::BIT_SINGLE_MIXER_ON]; // [R4]
         spk_mixer_on_ff <= WDATA_I[oejs_pkg::BIT_SPK_MIXER_ON]; // [R4]
      end
   end

   // Additional control
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         slow_tick_on_ff <= 1'b0;
      end else if (wr_add) begin
         slow_tick_on_ff <= WDATA_I[oejs_pkg::BIT_SLOW_TICK_ON]; // [R17]
      end
   end

   // Switch pin function and polarity
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         pin_function_sel_ff <= oejs_pkg::PFS_RESET;
         switch_pin_invert_ff <= 1'b0;
      end else if (wr_pin) begin
         pin_function_sel_ff <= WDATA_I[oejs_pkg::PFS_LSB +: oejs_pkg::PFS_W];
         switch_pin_invert_ff <= WDATA_I[oejs_pkg::BIT_SWITCH_PIN_INVERT];
      end
   end

   // Output control
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         tieoff_res_sel_ff <= 1'b0;
         overtemp_shutdown_on_ff <= oejs_pkg::OVERTEMP_SHUTDOWN_RESET; // [R15]
      end else if (wr_out) begin
         tieoff_res_sel_ff <= WDATA_I[oejs_pkg::BIT_TIEOFF_RES_SEL]; // [R7]
         overtemp_shutdown_on_ff <= WDATA_I[oejs_pkg::BIT_OVERTEMP_SHUTDOWN_ON]; // [R15]
      end
   end

   // Mono mixer control
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         bypass_atten_single_ff <= 1'b0;
         single_out_silence_ff <= 1'b0;
         aux_to_single_sel_ff <= 1'b0;
         bypass_to_single_sel_ff <= 1'b0;
         dac_to_single_sel_ff <= 1'b0;
      end else if (wr_mix) begin
         bypass_atten_single_ff <= WDATA_I[oejs_pkg::BIT_BYPASS_ATTEN_SINGLE]; // [R2]
         single_out_silence_ff <= WDATA_I[oejs_pkg::BIT_SINGLE_OUT_SILENCE]; // [R3]
         aux_to_single_sel_ff <= WDATA_I[oejs_pkg::BIT_AUX_TO_SINGLE_SEL]; // [R1]
         bypass_to_single_sel_ff <= WDATA_I[oejs_pkg::BIT_BYPASS_TO_SINGLE_SEL]; // [R1]
         dac_to_single_sel_ff <= WDATA_I[oejs_pkg::BIT_DAC_TO_SINGLE_SEL]; // [R1]
      end
   end

   // Event mask
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         evt_mask_ff <= '0;
      end else if (wr_mask) begin
         evt_mask_ff <= WDATA_I[oejs_pkg::EVT_W-1:0];
      end
   end

   // Slow tick divider; the counter clears while disabled so no tick escapes
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else if (slow_tick_on_ff) begin
         div_ff <= div_ff + 1'b1; // [R14]
         tick_ff <= &div_ff; // [R14]
      end else begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end
   end

   oejs_debounce u_debounce (
      .clk_i(CLOCK_I),
      .srst_i(SRST_I),
      .pin_i(SELECT_OR_SWITCH_PIN_I),
      .tick_i(tick_ff),
      .level_o(pin_level)
   );

   // Interface mode strap and over-temperature level both arrive asynchronously
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         mode_meta_ff <= 1'b0;
         mode_sync_ff <= 1'b0;
         ot_meta_ff <= 1'b0;
         ot_sync_ff <= 1'b0;
         ot_prev_ff <= 1'b0;
      end else begin
         mode_meta_ff <= TWO_WIRE_MODE_I;
         mode_sync_ff <= mode_meta_ff;
         ot_meta_ff <= OVERTEMP_I;
         ot_sync_ff <= ot_meta_ff;
         ot_prev_ff <= ot_sync_ff;
      end
   end

   assign switch_mode = mode_sync_ff && (pin_function_sel_ff == oejs_pkg::PFS_OUTPUT_SWITCH); // [R9]
   assign eff_level = pin_level ^ switch_pin_invert_ff; // [R10]
   // Shutdown only ever removes speaker drive; mono line load is small
   assign ot_shutdown = overtemp_shutdown_on_ff && ot_sync_ff;

   // Output gating: switch only gates what software already enabled
   always_comb begin
      nxt_spk_pos = spk_pos_on_ff;
      nxt_spk_neg = spk_neg_on_ff;
      nxt_single = single_out_on_ff;
      if (switch_mode) begin
         nxt_spk_pos = spk_pos_on_ff && !eff_level; // [R11] [R12]
         nxt_spk_neg = spk_neg_on_ff && !eff_level; // [R11] [R12]
         nxt_single = single_out_on_ff && eff_level; // [R11] [R12]
      end
      if (ot_shutdown) begin
         nxt_spk_pos = 1'b0;
         nxt_spk_neg = 1'b0;
      end
   end

   // Drive flags; a low flag means the selected tie-off resistor holds the pin
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         out_pos_ff <= 1'b0;
         out_neg_ff <= 1'b0;
         out_single_ff <= 1'b0;
      end else begin
         out_pos_ff <= nxt_spk_pos; // [R8]
         out_neg_ff <= nxt_spk_neg; // [R8]
         out_single_ff <= nxt_single; // [R8]
      end
   end

   // Switch level change is seen only while the pin acts as a switch
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         eff_level_ff <= 1'b0;
         eff_valid_ff <= 1'b0;
      end else begin
         eff_level_ff <= eff_level;
         eff_valid_ff <= switch_mode;
      end
   end

   always_comb begin
      evt_set = '0;
      evt_set[oejs_pkg::EVT_OVERTEMP] = ot_sync_ff && !ot_prev_ff; // [R16]
      evt_set[oejs_pkg::EVT_SWITCH_CHANGE] = switch_mode && eff_valid_ff && (eff_level != eff_level_ff);
   end

   // Sticky status: read clears, a new event in the same cycle wins
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         evt_status_ff <= '0;
      end else if (status_rd) begin
         evt_status_ff <= evt_set; // [R16]
      end else begin
         evt_status_ff <= evt_status_ff | evt_set; // [R16]
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_status_ff & evt_mask_ff);
      end
   end

   // Read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      nxt_rdata = oejs_pkg::REG_ZERO;
      unique case (ADDR_I)
         oejs_pkg::ADR_POWER_MANAGEMENT_ONE: begin
            nxt_rdata[oejs_pkg::BIT_AMP_BIAS_ON] = amp_bias_on_ff;
            nxt_rdata[oejs_pkg::BIT_MIDRAIL_BUFFER_ON] = midrail_buffer_on_ff;
         end
         oejs_pkg::ADR_POWER_MANAGEMENT_THREE: begin
            nxt_rdata[oejs_pkg::BIT_SINGLE_OUT_ON] = single_out_on_ff;
            nxt_rdata[oejs_pkg::BIT_SPK_NEG_ON] = spk_neg_on_ff;
            nxt_rdata[oejs_pkg::BIT_SPK_POS_ON] = spk_pos_on_ff;
            nxt_rdata[oejs_pkg::BIT_SINGLE_MIXER_ON] = single_mixer_on_ff;
            nxt_rdata[oejs_pkg::BIT_SPK_MIXER_ON] = spk_mixer_on_ff;
         end
         oejs_pkg::ADR_ADDITIONAL_CONTROL: begin
            nxt_rdata[oejs_pkg::BIT_SLOW_TICK_ON] = slow_tick_on_ff;
         end
         oejs_pkg::ADR_SWITCH_PIN_CONTROL: begin
            nxt_rdata[oejs_pkg::PFS_LSB +: oejs_pkg::PFS_W] = pin_function_sel_ff;
            nxt_rdata[oejs_pkg::BIT_SWITCH_PIN_INVERT] = switch_pin_invert_ff;
         end
         oejs_pkg::ADR_OUTPUT_CONTROL: begin
            nxt_rdata[oejs_pkg::BIT_TIEOFF_RES_SEL] = tieoff_res_sel_ff;
            nxt_rdata[oejs_pkg::BIT_OVERTEMP_SHUTDOWN_ON] = overtemp_shutdown_on_ff;
         end
         oejs_pkg::ADR_MONO_MIXER_CONTROL: begin
            nxt_rdata[oejs_pkg::BIT_BYPASS_ATTEN_SINGLE] = bypass_atten_single_ff;
            nxt_rdata[oejs_pkg::BIT_SINGLE_OUT_SILENCE] = single_out_silence_ff;
            nxt_rdata[oejs_pkg::BIT_AUX_TO_SINGLE_SEL] = aux_to_single_sel_ff;
            nxt_rdata[oejs_pkg::BIT_BYPASS_TO_SINGLE_SEL] = bypass_to_single_sel_ff;
            nxt_rdata[oejs_pkg::BIT_DAC_TO_SINGLE_SEL] = dac_to_single_sel_ff;
         end
         oejs_pkg::ADR_EVENT_STATUS: begin
            nxt_rdata[oejs_pkg::EVT_W-1:0] = evt_status_ff;
         end
         oejs_pkg::ADR_EVENT_MASK: begin
            nxt_rdata[oejs_pkg::EVT_W-1:0] = evt_mask_ff;
         end
         default: begin
            nxt_rdata = oejs_pkg::REG_ZERO;
         end
      endcase
   end

   // Read data is valid only in the cycle after the strobe
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         rdata_ff <= oejs_pkg::REG_ZERO;
      end else if (RD_I) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= oejs_pkg::REG_ZERO;
      end
   end

   // Outputs, all from flip-flops
   assign RDATA_O = rdata_ff;
   assign DAC_TO_SINGLE_SEL_O = dac_to_single_sel_ff; // [R1]
   assign BYPASS_TO_SINGLE_SEL_O = bypass_to_single_sel_ff; // [R1]
   assign AUX_TO_SINGLE_SEL_O = aux_to_single_sel_ff; // [R1]
   assign BYPASS_ATTEN_SINGLE_O = bypass_atten_single_ff; // [R2]
   assign SINGLE_OUT_SILENCE_O = single_out_silence_ff; // [R3]
   assign AMP_BIAS_ON_O = amp_bias_on_ff;
   assign MIDRAIL_BUFFER_ON_O = midrail_buffer_on_ff;
   assign SINGLE_MIXER_ON_O = single_mixer_on_ff;
   assign SPK_MIXER_ON_O = spk_mixer_on_ff;
   assign SINGLE_LINE_OUT_DRIVE_O = out_single_ff;
   assign SPEAKER_POS_DRIVE_O = out_pos_ff;
   assign SPEAKER_NEG_DRIVE_O = out_neg_ff;
   assign TIEOFF_RES_SEL_O = tieoff_res_sel_ff; // [R7]
   assign OVERTEMP_SHUTDOWN_ON_O = overtemp_shutdown_on_ff;
   assign SLOW_TICK_ON_O = slow_tick_on_ff;
   assign IRQ_O = irq_ff;
endmodule
`default_nettype wire

// File: tb/oejs_top_monitor.sv
// Concurrent checks on the ports of the output enable and jack switch block.
// Assumes it is bound into oejs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module oejs_top_monitor #(
   parameter int SLOW_DIV_LOG2 = 3
) (
   // Clock, reset and register port
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   input wire logic [oejs_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [oejs_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [oejs_pkg::DATA_W-1:0] RDATA_O,
   // Status input and control outputs
   input wire logic OVERTEMP_I,
   input wire logic DAC_TO_SINGLE_SEL_O,
   input wire logic BYPASS_TO_SINGLE_SEL_O,
   input wire logic AUX_TO_SINGLE_SEL_O,
   input wire logic BYPASS_ATTEN_SINGLE_O,
   input wire logic SINGLE_OUT_SILENCE_O,
   input wire logic AMP_BIAS_ON_O,
   input wire logic MIDRAIL_BUFFER_ON_O,
   input wire logic SINGLE_MIXER_ON_O,
   input wire logic SPK_MIXER_ON_O,
   input wire logic SPEAKER_POS_DRIVE_O,
   input wire logic SPEAKER_NEG_DRIVE_O,
   input wire logic TIEOFF_RES_SEL_O,
   input wire logic OVERTEMP_SHUTDOWN_ON_O
);
   logic [15:0] mono_view, pm1_view, pm3_view, oc_view;
   logic wr38, wr01, wr03, wr31, rd38, rd_unmapped;
   assign mono_view = {8'h00, BYPASS_ATTEN_SINGLE_O, SINGLE_OUT_SILENCE_O, 3'h0,
                       AUX_TO_SINGLE_SEL_O, BYPASS_TO_SINGLE_SEL_O, DAC_TO_SINGLE_SEL_O};
   assign pm1_view = {12'h000, AMP_BIAS_ON_O, MIDRAIL_BUFFER_ON_O, 2'h0};
   assign pm3_view = {12'h000, SINGLE_MIXER_ON_O, SPK_MIXER_ON_O, 2'h0};
   assign oc_view = {14'h0000, OVERTEMP_SHUTDOWN_ON_O, TIEOFF_RES_SEL_O};
   assign wr38 = WR_I && ADDR_I == 7'h38;
   assign wr01 = WR_I && ADDR_I == 7'h01;
   assign wr03 = WR_I && ADDR_I == 7'h03;
   assign wr31 = WR_I && ADDR_I == 7'h31;
   assign rd38 = RD_I && ADDR_I == 7'h38;
   assign rd_unmapped = RD_I && !(ADDR_I inside {7'h01, 7'h03, 7'h07, 7'h08, 7'h31, 7'h38, 7'h3a, 7'h3b});

   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (SRST_I);

   // Sensor must stay hot while shutdown is on long enough to pass the synchroniser
   sequence s_hot_held;
      (OVERTEMP_I && OVERTEMP_SHUTDOWN_ON_O)[*5];
   endsequence

   a_reset_values: assert property ($fell(SRST_I) |-> mono_view == 16'h0000 && pm1_view == 16'h0000
      && pm3_view == 16'h0000 && oc_view == 16'h0002 && !SPEAKER_POS_DRIVE_O && !SPEAKER_NEG_DRIVE_O)
      else $error("control outputs differ from reset values");
   a_rdata_idle: assert property (!RD_I |=> RDATA_O == 16'h0000)
      else $error("read data not zero outside a read");
   a_mono_readback: assert property (rd38 |=> RDATA_O == $past(mono_view))
      else $error("mono mixer readback differs from outputs");
   a_unmapped_read: assert property (rd_unmapped |=> RDATA_O == 16'h0000)
      else $error("unmapped read returned data");
   a_mono_write: assert property (wr38 |=> mono_view == ($past(WDATA_I) & 16'h00c7))
      else $error("mono mixer outputs do not follow write");
   a_mono_hold: assert property (!wr38 |=> $stable(mono_view))
      else $error("mono mixer outputs changed without write");
   a_pm1_write: assert property (wr01 |=> pm1_view == ($past(WDATA_I) & 16'h000c))
      else $error("bias or buffer enable does not follow write");
   a_pm3_write: assert property (wr03 |=> pm3_view == ($past(WDATA_I) & 16'h000c))
      else $error("mixer enables do not follow write");
   a_outctl_write: assert property (wr31 |=> oc_view == ($past(WDATA_I) & 16'h0003))
      else $error("output control outputs do not follow write");
   a_hot_speakers_off: assert property (s_hot_held |=> !SPEAKER_POS_DRIVE_O && !SPEAKER_NEG_DRIVE_O)
      else $error("speakers driven during thermal shutdown");
endmodule

bind oejs_top oejs_top_monitor #(.SLOW_DIV_LOG2(SLOW_DIV_LOG2)) u_monitor (
   .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .OVERTEMP_I(OVERTEMP_I), .DAC_TO_SINGLE_SEL_O(DAC_TO_SINGLE_SEL_O),
   .BYPASS_TO_SINGLE_SEL_O(BYPASS_TO_SINGLE_SEL_O), .AUX_TO_SINGLE_SEL_O(AUX_TO_SINGLE_SEL_O),
   .BYPASS_ATTEN_SINGLE_O(BYPASS_ATTEN_SINGLE_O), .SINGLE_OUT_SILENCE_O(SINGLE_OUT_SILENCE_O),
   .AMP_BIAS_ON_O(AMP_BIAS_ON_O), .MIDRAIL_BUFFER_ON_O(MIDRAIL_BUFFER_ON_O),
   .SINGLE_MIXER_ON_O(SINGLE_MIXER_ON_O), .SPK_MIXER_ON_O(SPK_MIXER_ON_O),
   .SPEAKER_POS_DRIVE_O(SPEAKER_POS_DRIVE_O), .SPEAKER_NEG_DRIVE_O(SPEAKER_NEG_DRIVE_O),
   .TIEOFF_RES_SEL_O(TIEOFF_RES_SEL_O), .OVERTEMP_SHUTDOWN_ON_O(OVERTEMP_SHUTDOWN_ON_O)
);
`default_nettype wire

// File: tb/oejs_top_tb.sv
// Self-checking bench for the output enable and jack switch block.
// Assumes a 25 MHz clock and a slow tick shortened to 2^3 master cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module oejs_top_tb;
   localparam int DIV = 3;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [6:0] addr = 7'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pin = 1'b0;
   logic twm = 1'b0;
   logic hot = 1'b0;
   logic [15:0] rdata, v, d;
   logic [6:0] a;
   logic mono_d, pos_d, neg_d, irq, tick_on, tsd_on, pol, lvl;
   logic [6:0] regs [9] = '{7'h01, 7'h03, 7'h07, 7'h08, 7'h31, 7'h38, 7'h3a, 7'h3b, 7'h55};
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 32'h938e5f7d;

   oejs_top #(.SLOW_DIV_LOG2(DIV)) u_dut (
      .CLOCK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .SELECT_OR_SWITCH_PIN_I(pin), .TWO_WIRE_MODE_I(twm), .OVERTEMP_I(hot),
      .DAC_TO_SINGLE_SEL_O(), .BYPASS_TO_SINGLE_SEL_O(), .AUX_TO_SINGLE_SEL_O(),
      .BYPASS_ATTEN_SINGLE_O(), .SINGLE_OUT_SILENCE_O(), .AMP_BIAS_ON_O(), .MIDRAIL_BUFFER_ON_O(),
      .SINGLE_MIXER_ON_O(), .SPK_MIXER_ON_O(), .SINGLE_LINE_OUT_DRIVE_O(mono_d),
      .SPEAKER_POS_DRIVE_O(pos_d), .SPEAKER_NEG_DRIVE_O(neg_d), .TIEOFF_RES_SEL_O(),
      .OVERTEMP_SHUTDOWN_ON_O(tsd_on), .SLOW_TICK_ON_O(tick_on), .IRQ_O(irq)
   );

   // Writable bits of each register; status and unmapped places give zero
   function automatic logic [15:0] rmask(input logic [6:0] ad);
      case (ad)
         7'h01: return 16'h000c;
         7'h03: return 16'h00ec;
         7'h07: return 16'h0001;
         7'h08: return 16'h000f;
         7'h31: return 16'h0003;
         7'h38: return 16'h00c7;
         7'h3b: return 16'h0003;
         default: return 16'h0000;
      endcase
   endfunction

   // Drives {mono, pos, neg} in switch mode with all three enables set
   function automatic logic [2:0] sw_drv(input logic eff);
      return eff ? 3'b100 : 3'b011;
   endfunction

   task automatic wr_reg(input logic [6:0] ad, input logic [15:0] dt);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= dt;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [6:0] ad, output logic [15:0] dt);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      dt = rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic give_verdict;
      $display("checks=%0d errors=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      forever #20 clk = ~clk;
   end

   // A hang costs one mismatch and ends the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_reg(regs[i], v);
         `CHK(v, (regs[i] == 7'h31) ? 16'h0002 : 16'h0000)
      end
      `CHK({tsd_on, irq, mono_d, pos_d, neg_d}, 5'b10000)
      // Random write and readback, status and unmapped places included
      for (int i = 0; i < 30; i++) begin
         a = regs[$unsigned($random(seed)) % 9];
         d = 16'($random(seed));
         wr_reg(a, d);
         rd_reg(a, v);
         `CHK(v, d & rmask(a))
      end
      wr_reg(7'h01, 16'h000c);
      wr_reg(7'h31, 16'h0002);
      wr_reg(7'h03, 16'h00e0);
      wait_cyc(3);
      `CHK({mono_d, pos_d, neg_d}, 3'b111)
      wr_reg(7'h03, 16'h0040);
      wait_cyc(3);
      `CHK({mono_d, pos_d, neg_d}, 3'b001)
      // Wrong pin function keeps plain enables even in two-wire mode
      twm <= 1'b1;
      wr_reg(7'h08, 16'h0002);
      wr_reg(7'h07, 16'h0001);
      wr_reg(7'h03, 16'h00e0);
      pin <= 1'b1;
      wait_cyc(40);
      `CHK({mono_d, pos_d, neg_d}, 3'b111)
      for (int i = 0; i < 8; i++) begin
         pol = (i < 4) ? i[1] : 1'($random(seed));
         lvl = (i < 4) ? i[0] : 1'($random(seed));
         wr_reg(7'h08, {12'h000, pol, 3'h1});
         pin <= lvl;
         wait_cyc(40);
         `CHK({mono_d, pos_d, neg_d}, sw_drv(lvl ^ pol))
      end
      // One-cycle glitches at seven of the eight phases of the slow tick are rejected
      for (int j = 0; j < 8; j++) begin
         wait_cyc(j);
         pin <= ~lvl;
         @(posedge clk);
         pin <= lvl;
         wait_cyc(30);
         `CHK({mono_d, pos_d, neg_d}, sw_drv(lvl ^ pol))
      end
      wr_reg(7'h07, 16'h0000);
      lvl = ~lvl;
      pin <= lvl;
      wait_cyc(40);
      `CHK({tick_on, mono_d, pos_d, neg_d}, {1'b0, sw_drv(~(lvl ^ pol))})
      wr_reg(7'h07, 16'h0001);
      wait_cyc(40);
      `CHK({tick_on, mono_d, pos_d, neg_d}, {1'b1, sw_drv(lvl ^ pol)})
      // Over-temperature event: masked, unmasked, cleared by reading
      twm <= 1'b0;
      wr_reg(7'h3b, 16'h0000);
      wait_cyc(4);
      rd_reg(7'h3a, v);
      hot <= 1'b1;
      wait_cyc(8);
      `CHK({irq, pos_d, neg_d}, 3'b000)
      wr_reg(7'h3b, 16'h0001);
      wait_cyc(2);
      `CHK(irq, 1'b1)
      rd_reg(7'h3a, v);
      `CHK(v, 16'h0001)
      wait_cyc(2);
      `CHK(irq, 1'b0)
      wr_reg(7'h31, 16'h0000);
      wait_cyc(3);
      `CHK({tsd_on, mono_d, pos_d, neg_d}, 4'b0111)
      give_verdict();
   end
endmodule
`default_nettype wire
